//--- src/pdb_pkg.sv
// Overview of operation
// R1 - Edge PWM: load value at modulo-1 to modulo
// R2 - Center PWM: load value at modulo-1 to modulo
// R3 - Free-running counter loads at FFFE to FFFF
// R4 - Center PWM: value equal modulo gives 100%
// R5 - Center PWM: value modulo-1 gives near 100%
// R6 - Zero to nonzero waits for new period
// R7 - Nonzero to zero finishes current period first
// R8 - Debug-halt status write clears modulo half-write
// R9 - Center counts up then down; match sets output
// R10 - Modulo 0000 or FFFF means free-running counter
// R11 - Per-channel buffer and both-bytes flag, cleared on load
package pdb_pkg;

    // Channel count and APB address width
    localparam int          NUM_CH        = 2;
    localparam int          ADDR_W        = 8;

    // Register byte addresses
    localparam logic [7:0]  ADDR_SC       = 8'h00;
    localparam logic [7:0]  ADDR_MOD_HI   = 8'h04;
    localparam logic [7:0]  ADDR_MOD_LO   = 8'h08;
    localparam logic [7:0]  ADDR_COUNT    = 8'h0c;
    localparam logic [7:0]  ADDR_CH_BASE  = 8'h10;
    localparam logic [7:0]  ADDR_CH_SPAN  = 8'h10;
    localparam logic [7:0]  OFS_CH_HI     = 8'h00;
    localparam logic [7:0]  OFS_CH_LO     = 8'h04;
    localparam logic [7:0]  OFS_CH_CTRL   = 8'h08;

    // Status and control field positions
    localparam int          SC_CLKS_LSB   = 0;
    localparam int          SC_CENTER     = 2;
    localparam int          SC_HALT       = 3;
    localparam int          SC_DOWN       = 4;

    // Channel control field positions
    localparam int          CC_ENABLE     = 0;
    localparam int          CC_INVERT     = 1;
    localparam int          CC_PENDING    = 2;

    // Counter constants and reset values
    localparam logic [15:0] CNT_ZERO      = 16'h0000;
    localparam logic [15:0] CNT_FULL      = 16'hffff;
    localparam logic [15:0] CNT_ONE       = 16'h0001;
    localparam logic [15:0] MOD_RESET     = 16'h0000;
    localparam logic [1:0]  CLKS_OFF      = 2'h0;

    // Counting direction, one-hot
    typedef enum logic [1:0] {
        PDB_UP   = 2'b01,
        PDB_DOWN = 2'b10
    } pdb_dir_t;

    // Shared timebase seen by every channel
    typedef struct packed {
        logic [15:0] count;   // Current counter value
        logic [15:0] top;     // Effective upper limit
        logic        center;  // Center-aligned mode
        logic        run;     // Counter is stepping
        logic        xfer;    // Counter steps top-1 to top
    } pdb_time_t;

    // Per-channel software configuration
    typedef struct packed {
        logic enable;  // Channel drives PWM
        logic invert;  // Output polarity
    } pdb_ch_cfg_t;

endpackage

//--- src/pdb_channel.sv
`timescale 1ns/10ps
// One PWM channel: two-byte buffer, active value and output
module pdb_channel
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              wr_hi,     // High byte write
    input  wire logic              wr_lo,     // Low byte write
    input  wire logic [7:0]        wbyte,     // Byte being written
    input  wire logic              coh_clear, // Drop half-written value
    input  wire pdb_pkg::pdb_time_t tb,       // Shared timebase
    input  wire pdb_pkg::pdb_ch_cfg_t cfg,    // Channel config
    output logic [15:0]            value,     // Active value
    output logic                   pending,   // Both bytes waiting
    output logic                   pwm_out    // Registered output
);

    // Whole channel state
    typedef struct packed {
        logic [7:0]  buf_hi;   // Buffered high byte
        logic [7:0]  buf_lo;   // Buffered low byte
        logic        hi_seen;  // High byte arrived
        logic        lo_seen;  // Low byte arrived
        logic [15:0] active;   // Value in use
        logic        out;      // Output level
    } pdb_ch_state_t;

    pdb_ch_state_t st_reg;   // Registered state
    pdb_ch_state_t st_next;  // Next state
    logic          level;    // Raw active level

    // Buffer, transfer and compare
    always_comb
    begin
        st_next = st_reg;
        // Capture written bytes
        if (wr_hi)
        begin
            st_next.buf_hi  = wbyte;
            st_next.hi_seen = 1'b1;
        end
        if (wr_lo)
        begin
            st_next.buf_lo  = wbyte;
            st_next.lo_seen = 1'b1;
        end
        if (coh_clear)
        begin
            st_next.hi_seen = 1'b0;
            st_next.lo_seen = 1'b0;
        end
        // Stopped timer: load as soon as both bytes are in
        if (!tb.run && st_next.hi_seen && st_next.lo_seen)
        begin
            st_next.active  = {st_next.buf_hi, st_next.buf_lo};
            st_next.hi_seen = 1'b0;  // see R11
            st_next.lo_seen = 1'b0;
        end
        // Running: load only on the step to top
        else if (tb.xfer && st_reg.hi_seen && st_reg.lo_seen)  // see R1, R2, R3
        begin
            // Old value kept up to here, whole period uses one value: see R6, R7
            st_next.active  = {st_reg.buf_hi, st_reg.buf_lo};
            st_next.hi_seen = wr_hi;  // see R11
            st_next.lo_seen = wr_lo;
        end
        // Active while below the value; center mode sets on down match,
        // clears on up match, and full when value reaches top
        if (tb.center)
        begin
            level = (tb.count < st_reg.active)            // see R9, R5
                  || (st_reg.active == tb.top);            // see R4
        end
        else
        begin
            level = (tb.count < st_reg.active);
        end
        st_next.out = cfg.enable & (level ^ cfg.invert);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs from state
    assign value   = st_reg.active;
    assign pending = st_reg.hi_seen & st_reg.lo_seen;
    assign pwm_out = st_reg.out;

endmodule // pdb_channel

//--- src/pdb_top.sv
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
// Timer/PWM duty buffer block with APB register access
module pdb_top
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [pdb_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        debug_halt_mode,
    output logic [pdb_pkg::NUM_CH-1:0]       pwm_out
);

    // Whole top-level state
    typedef struct packed {
        logic [15:0]       count;      // Timer counter
        pdb_pkg::pdb_dir_t dir;        // Count direction
        logic [15:0]       modulo;     // Active modulo value
        logic [7:0]        mod_hi;     // Modulo high byte buffer
        logic [7:0]        mod_lo;     // Modulo low byte buffer
        logic              mod_hi_seen;// Modulo high byte arrived
        logic              mod_lo_seen;// Modulo low byte arrived
        logic [1:0]        clks;       // Clock source select
        logic              center;     // Center-aligned mode
        logic [pdb_pkg::NUM_CH-1:0] ch_en;  // Channel enables
        logic [pdb_pkg::NUM_CH-1:0] ch_inv; // Channel polarity
        logic              halt_meta;  // Halt synchroniser stage 1
        logic              halt_sync;  // Halt synchroniser stage 2
        logic [31:0]       rdata;      // Read data register
    } pdb_top_state_t;

    pdb_top_state_t       st_reg;    // Registered state
    pdb_top_state_t       st_next;   // Next state
    pdb_pkg::pdb_time_t   tb;        // Timebase to channels
    logic                 wr_en;     // Write in access phase
    logic                 rd_setup;  // Read in setup phase
    logic                 mapped;    // Address decodes

    logic [pdb_pkg::NUM_CH-1:0] ch_wr_hi;   // Channel high byte strobes
    logic [pdb_pkg::NUM_CH-1:0] ch_wr_lo;   // Channel low byte strobes
    logic [pdb_pkg::NUM_CH-1:0] ch_pend;    // Channel pending flags
    logic [15:0]                ch_val [pdb_pkg::NUM_CH]; // Channel values
    logic                       coh_clear;  // Status write clears buffers

    // Effective top: 0000 and FFFF run free
    function automatic logic [15:0] top_of(input logic [15:0] m);
        if ((m == pdb_pkg::CNT_ZERO) || (m == pdb_pkg::CNT_FULL))  // see R10
        begin
            return pdb_pkg::CNT_FULL;
        end
        return m;
    endfunction

    // Address of a channel register
    function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] ofs);
        return 8'(pdb_pkg::ADDR_CH_BASE + 8'(ch) * pdb_pkg::ADDR_CH_SPAN + ofs);
    endfunction

    // Bus strobes
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign coh_clear = wr_en && (paddr == pdb_pkg::ADDR_SC);

    // Address decode
    always_comb
    begin
        mapped = (paddr == pdb_pkg::ADDR_SC) || (paddr == pdb_pkg::ADDR_MOD_HI)
              || (paddr == pdb_pkg::ADDR_MOD_LO) || (paddr == pdb_pkg::ADDR_COUNT);
        for (int i = 0; i < pdb_pkg::NUM_CH; i++)
        begin
            if ((paddr == ch_addr(i, pdb_pkg::OFS_CH_HI))
                || (paddr == ch_addr(i, pdb_pkg::OFS_CH_LO))
                || (paddr == ch_addr(i, pdb_pkg::OFS_CH_CTRL)))
            begin
                mapped = 1'b1;
            end
        end
    end

    // Channel write strobes
    always_comb
    begin
        for (int i = 0; i < pdb_pkg::NUM_CH; i++)
        begin
            ch_wr_hi[i] = wr_en && (paddr == ch_addr(i, pdb_pkg::OFS_CH_HI));
            ch_wr_lo[i] = wr_en && (paddr == ch_addr(i, pdb_pkg::OFS_CH_LO));
        end
    end

    // Timebase seen by channels
    always_comb
    begin
        tb.count  = st_reg.count;
        tb.top    = top_of(st_reg.modulo);
        tb.center = st_reg.center;
        tb.run    = (st_reg.clks != pdb_pkg::CLKS_OFF) && !st_reg.halt_sync;
        // Step from top-1 to top while counting up
        tb.xfer   = tb.run && (st_reg.dir == pdb_pkg::PDB_UP)
                 && (st_reg.count == 16'(tb.top - pdb_pkg::CNT_ONE));  // see R1, R2, R3
    end

    // Next-state logic: counter, modulo buffer, registers
    always_comb
    begin
        st_next = st_reg;
        // Debug halt input synchroniser
        st_next.halt_meta = debug_halt_mode;
        st_next.halt_sync = st_reg.halt_meta;

        // Counter stepping
        if (tb.run)
        begin
            if (!st_reg.center)
            begin
                // Edge mode: up to top then wrap
                st_next.dir = pdb_pkg::PDB_UP;
                if (st_reg.count >= tb.top)
                begin
                    st_next.count = pdb_pkg::CNT_ZERO;
                end
                else
                begin
                    st_next.count = 16'(st_reg.count + pdb_pkg::CNT_ONE);
                end
            end
            else if (st_reg.dir == pdb_pkg::PDB_UP)
            begin
                // Center mode up leg, turn at top
                if (st_reg.count >= tb.top)  // see R9
                begin
                    st_next.dir   = pdb_pkg::PDB_DOWN;
                    st_next.count = 16'(st_reg.count - pdb_pkg::CNT_ONE);
                end
                else
                begin
                    st_next.count = 16'(st_reg.count + pdb_pkg::CNT_ONE);
                end
            end
            else
            begin
                // Center mode down leg, turn at zero
                if (st_reg.count == pdb_pkg::CNT_ZERO)  // see R9
                begin
                    st_next.dir   = pdb_pkg::PDB_UP;
                    st_next.count = pdb_pkg::CNT_ONE;
                end
                else
                begin
                    st_next.count = 16'(st_reg.count - pdb_pkg::CNT_ONE);
                end
            end
        end

        // Register writes at the access edge
        if (wr_en)
        begin
            case (paddr)
                pdb_pkg::ADDR_SC:
                begin
                    st_next.clks   = pwdata[pdb_pkg::SC_CLKS_LSB +: 2];
                    st_next.center = pwdata[pdb_pkg::SC_CENTER];
                    // Halted: drop a half-written modulo
                    if (st_reg.halt_sync)
                    begin
                        st_next.mod_hi_seen = 1'b0;  // see R8
                        st_next.mod_lo_seen = 1'b0;
                    end
                end
                pdb_pkg::ADDR_MOD_HI:
                begin
                    st_next.mod_hi      = pwdata[7:0];
                    st_next.mod_hi_seen = 1'b1;
                end
                pdb_pkg::ADDR_MOD_LO:
                begin
                    st_next.mod_lo      = pwdata[7:0];
                    st_next.mod_lo_seen = 1'b1;
                end
                pdb_pkg::ADDR_COUNT:
                begin
                    // Any counter write restarts counting
                    st_next.count = pdb_pkg::CNT_ZERO;
                    st_next.dir   = pdb_pkg::PDB_UP;
                end
                default:
                begin
                    // Channel control registers
                    for (int i = 0; i < pdb_pkg::NUM_CH; i++)
                    begin
                        if (paddr == ch_addr(i, pdb_pkg::OFS_CH_CTRL))
                        begin
                            st_next.ch_en[i]  = pwdata[pdb_pkg::CC_ENABLE];
                            st_next.ch_inv[i] = pwdata[pdb_pkg::CC_INVERT];
                        end
                    end
                end
            endcase
        end

        // Modulo takes effect once both bytes are in
        if (st_next.mod_hi_seen && st_next.mod_lo_seen)
        begin
            st_next.modulo      = {st_next.mod_hi, st_next.mod_lo};
            st_next.mod_hi_seen = 1'b0;
            st_next.mod_lo_seen = 1'b0;
        end

        // Read data captured in the setup cycle
        if (rd_setup)
        begin
            st_next.rdata = '0;
            case (paddr)
                pdb_pkg::ADDR_SC:
                begin
                    st_next.rdata[pdb_pkg::SC_CLKS_LSB +: 2] = st_reg.clks;
                    st_next.rdata[pdb_pkg::SC_CENTER]        = st_reg.center;
                    st_next.rdata[pdb_pkg::SC_HALT]          = st_reg.halt_sync;
                    st_next.rdata[pdb_pkg::SC_DOWN]
                        = (st_reg.dir == pdb_pkg::PDB_DOWN);
                end
                pdb_pkg::ADDR_MOD_HI:
                begin
                    st_next.rdata[7:0] = st_reg.modulo[15:8];
                end
                pdb_pkg::ADDR_MOD_LO:
                begin
                    st_next.rdata[7:0] = st_reg.modulo[7:0];
                end
                pdb_pkg::ADDR_COUNT:
                begin
                    st_next.rdata[15:0] = st_reg.count;
                end
                default:
                begin
                    for (int i = 0; i < pdb_pkg::NUM_CH; i++)
                    begin
                        if (paddr == ch_addr(i, pdb_pkg::OFS_CH_HI))
                        begin
                            st_next.rdata[7:0] = ch_val[i][15:8];
                        end
                        if (paddr == ch_addr(i, pdb_pkg::OFS_CH_LO))
                        begin
                            st_next.rdata[7:0] = ch_val[i][7:0];
                        end
                        if (paddr == ch_addr(i, pdb_pkg::OFS_CH_CTRL))
                        begin
                            st_next.rdata[pdb_pkg::CC_ENABLE]  = st_reg.ch_en[i];
                            st_next.rdata[pdb_pkg::CC_INVERT]  = st_reg.ch_inv[i];
                            st_next.rdata[pdb_pkg::CC_PENDING] = ch_pend[i];
                        end
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg        <= '0;
            st_reg.dir    <= pdb_pkg::PDB_UP;
            st_reg.modulo <= pdb_pkg::MOD_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Channel instances
    for (genvar g = 0; g < pdb_pkg::NUM_CH; g++)
    begin : g_ch
        pdb_pkg::pdb_ch_cfg_t cfg;  // Channel configuration
        assign cfg.enable = st_reg.ch_en[g];
        assign cfg.invert = st_reg.ch_inv[g];
        pdb_channel u_ch
        (
            .pclk      (pclk),
            .presetn   (presetn),
            .wr_hi     (ch_wr_hi[g]),
            .wr_lo     (ch_wr_lo[g]),
            .wbyte     (pwdata[7:0]),
            .coh_clear (coh_clear),
            .tb        (tb),
            .cfg       (cfg),
            .value     (ch_val[g]),
            .pending   (ch_pend[g]),
            .pwm_out   (pwm_out[g])
        );
    end

    // Bus answers: zero wait, error on unmapped access
    assign prdata  = st_reg.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

endmodule // pdb_top

//--- sim/pdb_monitor.sv
`timescale 1ns/10ps
// Port-level checks on the duty buffer block
module pdb_monitor
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [pdb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       debug_halt_mode,
    input wire logic [pdb_pkg::NUM_CH-1:0] pwm_out
);
    logic [pdb_pkg::NUM_CH-1:0] en_seen;  // Channels enabled since reset
    logic                       mapped;   // Access hits a register

    // Decodes the register map
    always_comb mapped = (paddr[1:0] == 2'h0) && (paddr < 8'h30)
                         && ((paddr < 8'h10) || (paddr[3:2] != 2'h3));

    // Records which channels software has ever enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_seen <= '0;
        else if (psel && penable && pwrite && pwdata[0])
            en_seen <= en_seen | {paddr == 8'h28, paddr == 8'h18};
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_always_a: assert property (pready) else $error("pready low");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    err_unmapped_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access accepted");
    err_mapped_a: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access refused");
    unmapped_zero_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == '0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved without a read");
    halt_flag_a: assert property (psel && penable && !pwrite && paddr == 8'h00
        && $past(debug_halt_mode, 3) == $past(debug_halt_mode, 4)
        && $past(debug_halt_mode, 4) == $past(debug_halt_mode, 5)
        |-> prdata[3] == $past(debug_halt_mode, 3)) else $error("halt flag wrong");
    pwm_quiet_a: assert property ((pwm_out & ~en_seen) == '0)
        else $error("disabled channel active");

    cover property (psel && penable && !mapped);
    cover property (pwm_out[0]);
    cover property (psel && penable && pwrite && paddr == 8'h00 && debug_halt_mode);
endmodule // pdb_monitor

bind pdb_top pdb_monitor u_pdb_monitor
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debug_halt_mode(debug_halt_mode), .pwm_out(pwm_out)
);

//--- sim/pdb_top_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench driving the block over APB
module pdb_top_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        debug_halt_mode;
    logic [1:0]  pwm_out;
    int          failures;
    int          total_checks;
    logic [31:0] rd;    // Last read data
    logic        rerr;  // Last error response
    int          len;   // Measured high cycles

    pdb_top u_pdb_top
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_halt_mode(debug_halt_mode),
        .pwm_out(pwm_out)
    );

    // Counts a comparison and reports a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd   = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes a channel value, high byte then low byte
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        apb(1'b1, a, {24'h0, v[15:8]});
        apb(1'b1, a + 8'h04, {24'h0, v[7:0]});
    endtask

    // Counts high samples of channel 0 over a window
    task automatic duty(input int win);
        len = 0;
        repeat (win)
        begin
            @(negedge pclk);
            if (pwm_out[0] === 1'b1)
                len++;
        end
    endtask

    // Measures the next whole high pulse of channel 0
    task automatic pulse();
        while (pwm_out[0] !== 1'b0) @(negedge pclk);
        while (pwm_out[0] !== 1'b1) @(negedge pclk);
        len = 0;
        while (pwm_out[0] === 1'b1)
        begin
            @(negedge pclk);
            len++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic print_verdict();
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Bus clock, 20 ns period
    always #10 pclk = ~pclk;

    // Watchdog against a hung run
    initial
    begin
        #400000;
        failures++;
        print_verdict();
    end

    // Test sequence
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        debug_halt_mode = 1'b0;
        failures = 0;
        total_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Unmapped read is refused with zero data
        apb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        check(rerr, 1'b1);
        // Half a value has no effect; the second byte completes it
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check(rd[2], 1'b0);
        apb(1'b0, 8'h14, 32'h0);
        check(rd[7:0], 8'h00);
        apb(1'b1, 8'h14, 32'h04);
        apb(1'b0, 8'h14, 32'h0);
        check(rd[7:0], 8'h04);
        // A status write drops a half-written value; low then high pairs
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h14, 32'h02);
        apb(1'b0, 8'h14, 32'h0);
        check(rd[7:0], 8'h04);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check(rd[7:0], 8'h02);
        // Edge mode: a new value waits for the step to the modulo
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h40);
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        // Output lags one cycle; skip the sample of the stopped count
        @(posedge pclk);
        duty(65);
        check(len, 2);
        apb(1'b1, 8'h0c, 32'h0);
        wr16(8'h10, 16'h0020);
        apb(1'b0, 8'h18, 32'h0);
        check(rd[2], 1'b1);
        pulse();
        check(len, 32);
        apb(1'b0, 8'h18, 32'h0);
        check(rd[2], 1'b0);
        // Modulo zero runs free; no transfer at the old limit
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h0c, 32'h0);
        wr16(8'h10, 16'h0010);
        repeat (100) @(posedge pclk);
        apb(1'b0, 8'h0c, 32'h0);
        check(rd[15:0] > 16'h0040, 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        check(rd[2], 1'b1);
        // Center mode at and just below the modulo
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h10);
        apb(1'b1, 8'h00, 32'h5);
        apb(1'b1, 8'h0c, 32'h0);
        wr16(8'h10, 16'h0010);
        repeat (40) @(posedge pclk);
        duty(64);
        check(len, 64);
        wr16(8'h10, 16'h000f);
        repeat (40) @(posedge pclk);
        duty(32);
        check(len, 29);
        // Inverted polarity gives the complement of the period
        apb(1'b1, 8'h18, 32'h3);
        @(posedge pclk);
        duty(32);
        check(len, 3);
        apb(1'b1, 8'h18, 32'h1);
        // Changes to and from zero keep whole periods
        wr16(8'h10, 16'h0004);
        repeat (40) @(posedge pclk);
        apb(1'b1, 8'h0c, 32'h0);
        repeat (16) @(posedge pclk);
        wr16(8'h10, 16'h0000);
        pulse();
        check(len, 7);
        duty(64);
        check(len, 0);
        apb(1'b1, 8'h0c, 32'h0);
        repeat (16) @(posedge pclk);
        wr16(8'h10, 16'h0004);
        duty(20);
        check(len, 0);
        pulse();
        check(len, 7);
        // Debug halt: a status write drops a half-written modulo
        @(posedge pclk);
        debug_halt_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        check(rd[3], 1'b1);
        apb(1'b1, 8'h08, 32'h30);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, 32'h0);
        debug_halt_mode <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, 8'h0c, 32'h0);
        repeat (20) @(posedge pclk);
        apb(1'b0, 8'h0c, 32'h0);
        check(rd[15:0] <= 16'h0010, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        check(rd[7:0], 8'h10);
        print_verdict();
    end
endmodule // pdb_top_tb_top
